// *** rtl/ddrbp_ckgen.sv ***
// Purpose: Divides mclk by two to make the command clock
// Assumes: One clock domain
// Notes: rise is high in the cycle whose closing edge raises ck
`timescale 1ns/1ps
`default_nettype none
module ddrbp_ckgen (
	input wire logic mclk, // Controller clock
	input wire logic resetn, // Synchronous reset, active low
	output logic ck, // Command clock, from a flop
	output logic rise // Next edge raises ck
);
	logic ck_q;
	logic ck_d;
	always_comb begin
		ck_d = ~ck_q;
	end
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ck_q <= 1'b0;
		end else begin
			ck_q <= ck_d;
		end
	end
	assign ck = ck_q;
	assign rise = ~ck_q;
endmodule
`default_nettype wire

// *** rtl/ddrbp_ctrl.sv ***
// Purpose: Host controller issuing activate, read, write and precharge to a DDR2 device
// Assumes: Device mode registers already hold the length, type, CL and AL set in CTRL
// Notes: Commands wait until every spacing below is met; one command may be pending
// Summary of operation
// - Never interrupt a burst when the length is four.
// - Length eight read may be cut only by another read.
// - Length eight write may be cut only by another write.
// - An interrupting column command comes exactly two clocks after the previous.
// - The interrupting command may address any bank.
// - No interrupt of auto-precharge bursts; interrupter may carry auto-precharge.
// - Spacings after an interrupt use the programmed length.
// - No burst terminate command is ever sent.
// - Write latency is read latency minus one.
// - Host drives strobe preamble, then data on successive strobe edges.
// - One mask per eight data bits, write timing, unused on reads.
// - Read to precharge waits AL plus BL/2 plus max(RTP,2) minus 2.
// - Precharge only after active time; activate only after row precharge time.
// - Write to precharge waits WL plus BL/2 plus write recovery.
// - Column commands of one kind are at least two clocks apart.
// - RTP clocks are the read-to-precharge time rounded up to clocks.
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ddrbp_ctrl import ddrbp_pkg::*; #(
	parameter int DQW = 16
) (
	input wire logic mclk, // Controller clock, 10 MHz
	input wire logic resetn, // Synchronous reset, active low
	input wire logic [7:0] avs_address, // Register byte address
	input wire logic avs_read, // Register read request
	input wire logic avs_write, // Register write request
	input wire logic [31:0] avs_writedata, // Register write data
	output logic [31:0] avs_readdata, // Register read data
	output logic avs_waitrequest, // Request not yet taken
	output logic ck, // Command clock to device
	output logic csN, // Chip select, active low
	output logic rasN, // Row strobe, active low
	output logic casN, // Column strobe, active low
	output logic weN, // Write enable, active low
	output logic [1:0] ba, // Bank address
	output logic [12:0] addr, // Row or column address, A10 is precharge-all
	input wire logic [DQW-1:0] dqIn, // Data pins as seen
	output logic [DQW-1:0] dqOut, // Data driven on writes
	output logic dqOe, // High while driving data
	input wire logic dqsIn, // Strobe pin as seen, unused
	output logic dqsOut, // Strobe driven on writes
	output logic dqsOe, // High while driving the strobe
	output logic [DQW/8-1:0] dm // Write masks, one per byte
);
	localparam int DMW = DQW / 8;
	if (DQW < 8 || DQW % 8 != 0 || DMW > 16) begin : g_chk
		$error("DQW must be a multiple of 8 up to 128");
	end

	logic ckRise;
	ddrbp_ckgen u_ck (.mclk(mclk), .resetn(resetn), .ck(ck), .rise(ckRise));
	wire issueEdge = ~ckRise;

	// Register bank
	logic [9:0] ctrl_q, ctrl_d;
	logic wait_q, wait_d;
	logic [31:0] rdat_q, rdat_d;
	logic drop_q, drop_d, rdone_q, rdone_d;
	logic pend_q, pend_d;
	logic [17:0] pcmd_q, pcmd_d;
	logic [DQW-1:0] wbuf [8];
	logic [DMW-1:0] mbuf [8];
	logic [DQW-1:0] rbuf [8];
	logic wrActive_q, rdCapDone;
	logic issue;
	logic bl8, ilv;
	logic [3:0] cl, al, rl, wl, half;
	assign bl8 = (ctrl_q[CTRL_BL_LSB +: 3] == BL8_CODE);
	assign ilv = ctrl_q[CTRL_BT_BIT];
	assign cl = {1'b0, ctrl_q[CTRL_CL_LSB +: 3]};
	assign al = {1'b0, ctrl_q[CTRL_AL_LSB +: 3]};
	assign rl = al + cl;
	assign wl = rl - 4'h1;
	assign half = bl8 ? 4'h4 : 4'h2;
	wire take = (avs_read | avs_write) & ~wait_q;
	wire dataSel = (avs_address[7:5] == REG_DATA[7:5]);
	always_comb begin
		ctrl_d = ctrl_q;
		pend_d = pend_q;
		pcmd_d = pcmd_q;
		drop_d = drop_q;
		rdone_d = rdone_q;
		rdat_d = rdat_q;
		wait_d = 1'b1;
		if ((avs_read | avs_write) && wait_q) begin
			wait_d = 1'b0;
			rdat_d = 32'h0;
			if (dataSel) begin
				rdat_d[DQW-1:0] = rbuf[avs_address[4:2]];
			end else if (avs_address == REG_CTRL) begin
				rdat_d[9:0] = ctrl_q;
			end else if (avs_address == REG_STAT) begin
				rdat_d[STAT_PEND] = pend_q;
				rdat_d[STAT_DROP] = drop_q;
				rdat_d[STAT_WACT] = wrActive_q;
				rdat_d[STAT_RDONE] = rdone_q;
			end
		end
		if (issue) begin
			pend_d = 1'b0;
		end
		if (take && avs_write) begin
			if (avs_address == REG_CTRL) begin
				ctrl_d = avs_writedata[9:0];
			end else if (avs_address == REG_CMD) begin
				if (pend_q) begin
					drop_d = 1'b1;
				end else begin
					pend_d = 1'b1;
					pcmd_d = avs_writedata[17:0];
				end
			end else if (avs_address == REG_STAT) begin
				if (avs_writedata[STAT_DROP]) begin
					drop_d = 1'b0;
				end
				if (avs_writedata[STAT_RDONE]) begin
					rdone_d = 1'b0;
				end
			end
		end
		if (rdCapDone) begin
			rdone_d = 1'b1;
		end
	end
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ctrl_q <= CTRL_RST;
			wait_q <= 1'b1;
			rdat_q <= 32'h0;
			drop_q <= 1'b0;
			rdone_q <= 1'b0;
			pend_q <= 1'b0;
			pcmd_q <= 18'h0;
		end else begin
			ctrl_q <= ctrl_d;
			wait_q <= wait_d;
			rdat_q <= rdat_d;
			drop_q <= drop_d;
			rdone_q <= rdone_d;
			pend_q <= pend_d;
			pcmd_q <= pcmd_d;
		end
	end
	always_ff @(posedge mclk) begin
		if (take && avs_write && dataSel) begin
			wbuf[avs_address[4:2]] <= avs_writedata[DQW-1:0];
			mbuf[avs_address[4:2]] <= avs_writedata[DATA_MASK_LSB +: DMW];
		end
	end
	assign avs_waitrequest = wait_q;
	assign avs_readdata = rdat_q;

	// Command issue and spacing
	ddrbp_op_t pOp;
	assign pOp = ddrbp_op_t'(pcmd_q[CMD_OP_LSB +: 2]);
	wire pAp = pcmd_q[CMD_AP_BIT];
	wire [1:0] pBa = pcmd_q[CMD_BA_LSB +: 2];
	wire [12:0] pAddr = pcmd_q[CMD_ADDR_LSB +: 13];
	wire isCol = (pOp == OP_RD) || (pOp == OP_WR);
	logic [3:0] preZero, actZero;
	logic colZero;
	logic [2:0] since_q, since_d;
	logic lastWr_q, lastWr_d, lastAp_q, lastAp_d;
	logic [3:0] cmd_q, cmd_d;
	logic [1:0] ba_q, ba_d;
	logic [12:0] addr_q, addr_d;
	logic legal, intOk;
	wire [5:0] rdPre = 6'(al) + 6'(half) + 6'(RTP_EFF) - 6'h2;
	wire [5:0] wrPre = 6'(wl) + 6'(half) + 6'(WR_CK);
	wire [5:0] colEnd = 6'((pOp == OP_RD) ? rl : wl) + 6'(half);
	assign intOk = bl8 && (lastWr_q == (pOp == OP_WR)) && !lastAp_q
		&& since_q == 3'(INT_GAP_CK);
	always_comb begin
		legal = 1'b0;
		unique case (pOp)
			OP_RD, OP_WR: legal = (since_q >= 3'(CCD_CK)) && (colZero || intOk);
			OP_PRE: legal = pAp ? (preZero == 4'hf) : preZero[pBa];
			OP_ACT: legal = actZero[pBa];
		endcase
	end
	assign issue = pend_q && issueEdge && legal;
	genvar b;
	for (b = 0; b < 4; b++) begin : g_bank
		wire hitB = (pBa == 2'(b));
		ddrbp_timer #(.W(6)) u_pre (.mclk(mclk), .resetn(resetn), .tick(ckRise),
			.load(issue && hitB && pOp != OP_PRE),
			.val((pOp == OP_ACT) ? 6'(RAS_CK) : ((pOp == OP_RD) ? rdPre : wrPre)),
			.zero(preZero[b]));
		ddrbp_timer #(.W(6)) u_act (.mclk(mclk), .resetn(resetn), .tick(ckRise),
			.load(issue && pOp == OP_PRE && (pAp || hitB)), .val(6'(RP_CK)),
			.zero(actZero[b]));
	end
	ddrbp_timer #(.W(6)) u_col (.mclk(mclk), .resetn(resetn), .tick(ckRise),
		.load(issue && isCol), .val(colEnd), .zero(colZero));
	always_comb begin
		since_d = since_q;
		lastWr_d = lastWr_q;
		lastAp_d = lastAp_q;
		cmd_d = cmd_q;
		ba_d = ba_q;
		addr_d = addr_q;
		if (ckRise && since_q != 3'h7) begin
			since_d = since_q + 3'h1;
		end
		if (issueEdge) begin
			cmd_d = 4'b0111;
		end
		if (issue) begin
			ba_d = pBa;
			addr_d = pAddr;
			unique case (pOp)
				OP_ACT: cmd_d = 4'b0011;
				OP_RD: cmd_d = 4'b0101;
				OP_WR: cmd_d = 4'b0100;
				OP_PRE: cmd_d = 4'b0010;
			endcase
			if (pOp != OP_ACT) begin
				addr_d[AP_ADDR_BIT] = pAp;
			end
			if (isCol) begin
				since_d = 3'h0;
				lastWr_d = (pOp == OP_WR);
				lastAp_d = pAp;
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			since_q <= 3'h7;
			lastWr_q <= 1'b0;
			lastAp_q <= 1'b0;
			cmd_q <= 4'b1111;
			ba_q <= 2'h0;
			addr_q <= 13'h0;
		end else begin
			since_q <= since_d;
			lastWr_q <= lastWr_d;
			lastAp_q <= lastAp_d;
			cmd_q <= cmd_d;
			ba_q <= ba_d;
			addr_q <= addr_d;
		end
	end
	assign {csN, rasN, casN, weN} = cmd_q;
	assign ba = ba_q;
	assign addr = addr_q;

	// Write data path, timed from the issue edge in mclk cycles
	logic [5:0] wWait_q, wWait_d;
	logic [3:0] wRem_q, wRem_d;
	logic [2:0] wIdx_q, wIdx_d;
	logic wPost_q, wPost_d;
	logic [DQW-1:0] dq_q, dq_d;
	logic dqs_q, dqs_d, oe_q, oe_d;
	logic [DMW-1:0] dm_q, dm_d;
	wire wStart = (wWait_q == 6'h1);
	always_comb begin
		wWait_d = (wWait_q != 6'h0) ? wWait_q - 6'h1 : 6'h0;
		wRem_d = wRem_q;
		wIdx_d = wIdx_q;
		wPost_d = 1'b0;
		dq_d = dq_q;
		dqs_d = 1'b0;
		oe_d = 1'b0;
		dm_d = '0;
		if (issue && pOp == OP_WR) begin
			wWait_d = 6'({wl, 1'b1});
		end
		if (wStart || wRem_q != 4'h0) begin
			wIdx_d = wStart ? 3'h0 : wIdx_q;
			dq_d = wbuf[wIdx_d];
			dm_d = mbuf[wIdx_d];
			dqs_d = ~wIdx_d[0];
			oe_d = 1'b1;
			wRem_d = (wStart ? 4'({half, 1'b0}) : wRem_q) - 4'h1;
			wIdx_d = wIdx_d + 3'h1;
			wPost_d = (wRem_d == 4'h0);
		end else if (wPost_q) begin
			oe_d = 1'b1;
		end
		if (wWait_q == 6'h2) begin
			oe_d = 1'b1;
			dqs_d = 1'b0;
		end
	end
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wWait_q <= 6'h0;
			wRem_q <= 4'h0;
			wIdx_q <= 3'h0;
			wPost_q <= 1'b0;
			dq_q <= '0;
			dqs_q <= 1'b0;
			oe_q <= 1'b0;
			dm_q <= '0;
			wrActive_q <= 1'b0;
		end else begin
			wWait_q <= wWait_d;
			wRem_q <= wRem_d;
			wIdx_q <= wIdx_d;
			wPost_q <= wPost_d;
			dq_q <= dq_d;
			dqs_q <= dqs_d;
			oe_q <= oe_d;
			dm_q <= dm_d;
			wrActive_q <= oe_d;
		end
	end
	assign dqOut = dq_q;
	assign dqOe = oe_q;
	assign dqsOut = dqs_q;
	assign dqsOe = oe_q;
	assign dm = dm_q;

	// Read capture after read latency plus synchroniser delay
	logic [DQW-1:0] sync1_q, sync2_q;
	logic [5:0] rWait_q, rWait_d;
	logic [3:0] rRem_q, rRem_d;
	logic [2:0] rN_q, rN_d, rSt_q, rSt_d;
	wire rStart = (rWait_q == 6'h1);
	wire rCap = rStart || rRem_q != 4'h0;
	wire [2:0] rNow = rStart ? 3'h0 : rN_q;
	assign rdCapDone = rCap && rRem_d == 4'h0;
	always_comb begin
		rWait_d = (rWait_q != 6'h0) ? rWait_q - 6'h1 : 6'h0;
		rRem_d = rRem_q;
		rN_d = rN_q;
		rSt_d = rSt_q;
		if (issue && pOp == OP_RD) begin
			rWait_d = 6'({rl, 1'b0}) + 6'(SYNC_STAGES + 2);
			rSt_d = pAddr[2:0];
		end
		if (rCap) begin
			rRem_d = (rStart ? 4'({half, 1'b0}) : rRem_q) - 4'h1;
			rN_d = rNow + 3'h1;
		end
	end
	always_ff @(posedge mclk) begin
		sync1_q <= dqIn;
		sync2_q <= sync1_q;
		if (rCap) begin
			rbuf[colOrder(rSt_q, rNow, bl8, ilv)] <= sync2_q;
		end
	end
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rWait_q <= 6'h0;
			rRem_q <= 4'h0;
			rN_q <= 3'h0;
			rSt_q <= 3'h0;
		end else begin
			rWait_q <= rWait_d;
			rRem_q <= rRem_d;
			rN_q <= rN_d;
			rSt_q <= rSt_d;
		end
	end

	logic [5:0] wAge_q;
	always_ff @(posedge mclk) begin
		if (!resetn || (issue && pOp == OP_WR)) begin
			wAge_q <= 6'h0;
		end else if (wAge_q != 6'h3f) begin
			wAge_q <= wAge_q + 6'h1;
		end
	end
	wire colIss = issue && isCol;
	AST_BL4_NOINT: assert property (@(posedge mclk) disable iff (!resetn)
		colIss && !bl8 |-> colZero) else $error("burst of four interrupted");
	AST_INT_DIR: assert property (@(posedge mclk) disable iff (!resetn)
		colIss && !colZero |-> lastWr_q == (pOp == OP_WR)) else $error("interrupt direction");
	AST_INT_GAP: assert property (@(posedge mclk) disable iff (!resetn)
		colIss && !colZero |-> since_q == 3'h2 && !lastAp_q) else $error("interrupt spacing");
	AST_CCD: assert property (@(posedge mclk) disable iff (!resetn)
		colIss |=> !colIss [*3]) else $error("column commands too close");
	AST_NO_TERM: assert property (@(posedge mclk) disable iff (!resetn)
		cmd_q != 4'b0110) else $error("terminate code driven");
	AST_PRE_WAIT: assert property (@(posedge mclk) disable iff (!resetn)
		issue && pOp == OP_PRE && !pAp |-> preZero[pBa]) else $error("early precharge");
	AST_ACT_WAIT: assert property (@(posedge mclk) disable iff (!resetn)
		issue && pOp == OP_ACT |-> actZero[pBa]) else $error("activate inside precharge");
	AST_WL: assert property (@(posedge mclk) disable iff (!resetn)
		wStart |-> wAge_q == 6'({wl, 1'b0})) else $error("write latency wrong");
	AST_PREAMBLE: assert property (@(posedge mclk) disable iff (!resetn)
		wStart && wRem_q == 4'h0 |=> $past(oe_q) && !$past(dqs_q) && dqs_q)
		else $error("strobe preamble missing");
	AST_DM_IDLE: assert property (@(posedge mclk) disable iff (!resetn)
		!oe_q |-> dm_q == '0) else $error("mask driven outside write");
	AST_BUS_ONE: assert property (@(posedge mclk) disable iff (!resetn)
		!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
	COV_WRITE: cover property (@(posedge mclk) disable iff (!resetn) wStart);
	COV_READ: cover property (@(posedge mclk) disable iff (!resetn) rdCapDone);
	COV_INT: cover property (@(posedge mclk) disable iff (!resetn) colIss && !colZero);
	COV_PALL: cover property (@(posedge mclk) disable iff (!resetn) issue && pOp == OP_PRE && pAp);
endmodule
`default_nettype wire

// *** rtl/ddrbp_pkg.sv ***
// Purpose: Shared constants, types and helpers of the burst/precharge controller
// Assumes: Controller clock mclk at 10 MHz, command clock at half that rate
// Notes: Register map and field positions live here only
package ddrbp_pkg;
	localparam int MCLK_NS = 100;
	localparam int CK_NS = 2 * MCLK_NS;
	localparam int T_RAS_NS = 45;
	localparam int T_RP_NS = 15;
	localparam int T_RTP_NS = 8;
	localparam int T_WR_NS = 15;
	// Least times rounded up to whole command clocks
	localparam int RAS_CK = (T_RAS_NS + CK_NS - 1) / CK_NS;
	localparam int RP_CK = (T_RP_NS + CK_NS - 1) / CK_NS;
	localparam int RTP_CK = (T_RTP_NS + CK_NS - 1) / CK_NS;
	localparam int WR_CK = (T_WR_NS + CK_NS - 1) / CK_NS;
	localparam int MIN_GAP_CK = 2;
	localparam int RTP_EFF = (RTP_CK > MIN_GAP_CK) ? RTP_CK : MIN_GAP_CK;
	localparam int INT_GAP_CK = 2;
	localparam int CCD_CK = 2;
	localparam int SYNC_STAGES = 2;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_DATA = 8'h20;
	localparam int CTRL_BL_LSB = 0;
	localparam int CTRL_BT_BIT = 3;
	localparam int CTRL_CL_LSB = 4;
	localparam int CTRL_AL_LSB = 7;
	localparam logic [9:0] CTRL_RST = 10'h032;
	localparam logic [2:0] BL8_CODE = 3'h3;
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_AP_BIT = 2;
	localparam int CMD_BA_LSB = 3;
	localparam int CMD_ADDR_LSB = 5;
	localparam int STAT_PEND = 0;
	localparam int STAT_DROP = 1;
	localparam int STAT_WACT = 2;
	localparam int STAT_RDONE = 3;
	localparam int DATA_MASK_LSB = 16;
	localparam int AP_ADDR_BIT = 10;

	typedef enum logic [1:0] {
		OP_ACT = 2'h0,
		OP_RD = 2'h1,
		OP_WR = 2'h2,
		OP_PRE = 2'h3
	} ddrbp_op_t;

	// Column offset of beat n for a start column, length and ordering
	function automatic logic [2:0] colOrder(input logic [2:0] s, input logic [2:0] n,
		input logic bl8, input logic ilv);
		logic [2:0] c;
		c = 3'h0;
		if (ilv) begin
			c = s ^ n;
		end else begin
			c[1:0] = s[1:0] + n[1:0];
			c[2] = s[2] ^ n[2];
		end
		if (!bl8) begin
			c[2] = 1'b0;
		end
		return c;
	endfunction
endpackage

// *** rtl/ddrbp_timer.sv ***
// Purpose: Down counter of command clocks that keeps the later of two deadlines
// Assumes: tick is a one-cycle enable once per command clock
// Notes: zero means the guarded command may go
`timescale 1ns/1ps
`default_nettype none
module ddrbp_timer #(
	parameter int W = 6
) (
	input wire logic mclk, // Controller clock
	input wire logic resetn, // Synchronous reset, active low
	input wire logic tick, // Command clock enable
	input wire logic load, // Start or extend the wait
	input wire logic [W-1:0] val, // Wait in command clocks
	output logic zero // Wait has run out
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	always_comb begin
		cnt_d = cnt_q;
		if (tick && cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
		if (load && val > cnt_d) begin
			cnt_d = val;
		end
	end
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	assign zero = (cnt_q == '0);
endmodule
`default_nettype wire

// *** verif/ddrbp_ctrl_tb_top.sv ***
// Purpose: Self-checking bench of the DDR2 burst and precharge controller
// Assumes: Device model answers at the pins; Avalon requests come from here
// Notes: Expected data worked out from ordering and mask behaviour
`timescale 1ns/1ps
`default_nettype none
module ddrbp_ctrl_tb_top import ddrbp_pkg::*;;
	logic mclk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, ap, bl8 = 1'b0, ilv = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic avs_waitrequest, ck, csN, rasN, casN, weN, dqOe, dqsIn, dqsOut, dqsOe;
	logic [1:0] ba, dm, bk;
	logic [12:0] addr;
	logic [15:0] dqIn, dqOut;
	logic [2:0] al = 3'h0, cl = 3'h3, col;
	logic [15:0] w [8], ex [8];
	logic [1:0] mk [8];
	logic [3:0] opn = 4'h0;
	int num_errors = 0, checked = 0, viol;
	always #50 mclk = ~mclk;
	ddrbp_ctrl ddrbp_ctrl_i (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ck(ck), .csN(csN),
		.rasN(rasN), .casN(casN), .weN(weN), .ba(ba), .addr(addr), .dqIn(dqIn), .dqOut(dqOut),
		.dqOe(dqOe), .dqsIn(dqsIn), .dqsOut(dqsOut), .dqsOe(dqsOe), .dm(dm));
	ddrbp_dev_model ddrbp_dev_model_i (.mclk(mclk), .ck(ck), .csN(csN), .rasN(rasN),
		.casN(casN), .weN(weN), .ba(ba), .addr(addr), .dqOut(dqOut), .dqOe(dqOe),
		.dqsOut(dqsOut), .dqsOe(dqsOe), .dm(dm), .bl8(bl8), .ilv(ilv), .al(al), .cl(cl),
		.dqIn(dqIn), .dqsIn(dqsIn), .viol(viol));
	task automatic complete_run();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do begin
			@(posedge mclk);
			n++;
			if (n > 50) begin
				num_errors++;
				complete_run();
			end
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic cmd(input ddrbp_op_t op, input logic a10, input logic [12:0] a);
		bus(1'b1, REG_CMD, 32'(op) << CMD_OP_LSB | 32'(a10) << CMD_AP_BIT |
			32'(bk) << CMD_BA_LSB | 32'(a) << CMD_ADDR_LSB);
	endtask
	task automatic waitst(input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			bus(1'b0, REG_STAT, 32'h0);
			n++;
			if (n > 200) begin
				num_errors++;
				complete_run();
			end
		end while ((q & m) !== v);
	endtask
	initial begin
		void'($urandom(32'h6b109036));
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		bus(1'b0, REG_CTRL, 32'h0);
		chk(q, 32'(CTRL_RST));
		bus(1'b0, 8'h44, 32'h0);
		chk(q, 32'h0);
		for (int i = 0; i < 8; i++) ex[i] = 16'h0;
		for (int m = 0; m < 12; m++) begin
			bl8 = m[0];
			ilv = m[1];
			cl = 3'(2 + $urandom % 3);
			al = 3'($urandom % 3);
			col = m < 8 ? m[2:0] : 3'($urandom);
			bk = 2'($urandom);
			bus(1'b1, REG_CTRL, 32'(al) << CTRL_AL_LSB | 32'(cl) << CTRL_CL_LSB |
				32'(ilv) << CTRL_BT_BIT | 32'(bl8 ? BL8_CODE : 3'h2));
			cmd(OP_ACT, 1'b0, 13'($urandom));
			opn[bk] = 1'b1;
			for (int i = 0; i < 8; i++) begin
				w[i] = 16'($urandom);
				mk[i] = 2'($urandom);
				bus(1'b1, 8'(REG_DATA + 4 * i), {14'h0, mk[i], w[i]});
			end
			cmd(OP_WR, 1'b0, 13'({6'($urandom), col}));
			// Back-to-back write: interrupt on length eight, wait on four
			if (m[2]) cmd(OP_WR, 1'b0, 13'({6'($urandom), col}));
			waitst(32'h1 << STAT_PEND | 32'h1 << STAT_WACT, 32'h0);
			for (int n = 0; n < (bl8 ? 8 : 4); n++) begin
				for (int b = 0; b < 2; b++) begin
					if (!mk[n][b]) ex[ddrbp_dev_model_i.ord(col, n[2:0], bl8, ilv)][8*b +: 8] = w[n][8*b +: 8];
				end
			end
			cmd(OP_RD, 1'b0, 13'({6'($urandom), col}));
			waitst(32'h1 << STAT_PEND | 32'h1 << STAT_RDONE, 32'h1 << STAT_RDONE);
			for (int i = 0; i < (bl8 ? 8 : 4); i++) begin
				bus(1'b0, 8'(REG_DATA + 4 * i), 32'h0);
				chk(32'(q[15:0]), 32'(ex[i]));
				chk(32'(ddrbp_dev_model_i.mem[i]), 32'(ex[i]));
			end
			bus(1'b1, REG_STAT, 32'h1 << STAT_RDONE);
			ap = 1'($urandom);
			cmd(OP_PRE, ap, 13'h0);
			waitst(32'h1 << STAT_PEND, 32'h0);
			opn = ap ? 4'h0 : opn & ~(4'h1 << bk);
			chk(32'(ddrbp_dev_model_i.open), 32'(opn));
		end
		chk(32'(viol), 32'h0);
		complete_run();
	end
endmodule
`default_nettype wire

// *** verif/ddrbp_dev_model.sv ***
// Purpose: Behavioural four-bank DDR2 device seen at the controller's pins
// Assumes: Mode values come from the bench; read data launched on mclk edges
// Notes: viol counts spacing and interrupt breaks made by the controller
`timescale 1ns/1ps
`default_nettype none
module ddrbp_dev_model import ddrbp_pkg::*; (
	input wire logic mclk, // Controller clock
	input wire logic ck, // Command clock
	input wire logic csN, // Chip select
	input wire logic rasN, // Row strobe
	input wire logic casN, // Column strobe
	input wire logic weN, // Write enable
	input wire logic [1:0] ba, // Bank
	input wire logic [12:0] addr, // Address
	input wire logic [15:0] dqOut, // Host data
	input wire logic dqOe, // Host drives data
	input wire logic dqsOut, // Host strobe
	input wire logic dqsOe, // Host drives strobe
	input wire logic [1:0] dm, // Write masks
	input wire logic bl8, // Length eight
	input wire logic ilv, // Interleaved order
	input wire logic [2:0] al, // Additive latency
	input wire logic [2:0] cl, // CAS latency
	output logic [15:0] dqIn, // Data line level
	output logic dqsIn, // Strobe line level
	output int viol // Breaks seen
);
	logic [15:0] mem [8] = '{default: 16'h0};
	logic [15:0] drv = 16'h0;
	logic [15:0] junk = 16'ha5a5;
	logic [3:0] open = 4'h0;
	logic rdOn = 1'b0;
	logic lastWe = 1'b1;
	logic lastAp = 1'b0;
	int ckn = 0, lastCol = -99, lastRd = -99, lastWr = -99, lastAct = -99, bid = 0, bl, gap;
	int lastPre = -99;
	initial viol = 0;
	initial dqsIn = 1'b1;
	assign bl = bl8 ? 8 : 4;
	// Released line shows a changing pattern
	assign dqIn = dqOe ? dqOut : (rdOn ? drv : junk);
	always @(posedge mclk) junk <= junk + 16'h3c5b;
	function automatic logic [2:0] ord(input logic [2:0] s, input logic [2:0] n,
		input logic b8, input logic il);
		logic [2:0] c;
		c = il ? s ^ n : {s[2] ^ n[2], s[1:0] + n[1:0]};
		return b8 ? c : {1'b0, c[1:0]};
	endfunction
	task automatic burst(input logic wr, input logic [2:0] s, input int id);
		repeat (2 * (al + cl) - 2) @(posedge mclk);
		if (!wr && id == bid) dqsIn <= 1'b0;
		@(posedge mclk);
		if (!wr) @(posedge mclk);
		for (int k = 0; k < bl; k++) begin
			if (id != bid) break;
			if (wr) begin
				if (!(dqsOe && dqOe && dqsOut == !k[0])) viol++;
				for (int b = 0; b < 2; b++) begin
					if (!dm[b]) mem[ord(s, k[2:0], bl8, ilv)][8*b +: 8] = dqOut[8*b +: 8];
				end
			end else begin
				drv <= mem[ord(s, k[2:0], bl8, ilv)];
				dqsIn <= !k[0];
				rdOn <= 1'b1;
			end
			@(posedge mclk);
		end
		if (!wr && id == bid) rdOn <= 1'b0;
	endtask
	always @(posedge ck) begin
		ckn++;
		case ({csN, rasN, casN, weN})
		4'h3: begin
			if (ckn - lastPre < RP_CK) viol++;
			open[ba] = 1'b1;
			lastAct = ckn;
		end
		4'h2: begin
			if (ckn - lastRd < al + bl / 2 + RTP_EFF - 2 || ckn - lastAct < RAS_CK ||
				ckn - lastWr < al + cl - 1 + bl / 2 + WR_CK) viol++;
			lastPre = ckn;
			if (addr[AP_ADDR_BIT]) open = 4'h0;
			else open[ba] = 1'b0;
		end
		4'h4, 4'h5: begin
			gap = ckn - lastCol;
			if (gap < CCD_CK || (gap < bl / 2 && (!bl8 || gap != INT_GAP_CK ||
				weN != lastWe || lastAp))) viol++;
			lastCol = ckn;
			lastWe = weN;
			lastAp = addr[AP_ADDR_BIT];
			if (weN) lastRd = ckn;
			else lastWr = ckn;
			bid++;
			fork
				burst(!weN, addr[2:0], bid);
			join_none
		end
		4'h6: viol++;
		default: ;
		endcase
	end
endmodule
`default_nettype wire
